// ===== camcd_host.sv
// Host model: AHB-Lite master issuing single word transfers to the decoder
`timescale 1ns/1ps
`default_nettype none
module camcd_host
(
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  logic rdy_q;
  logic [31:0] rdata_q;

  // Edge samples, so read data is the value seen at the edge itself
  always @(posedge clk)
  begin
    rdy_q <= hready;
    rdata_q <= hrdata;
  end

  initial
  begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end

  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (rdy_q !== 1'b1 && n < 50);
    if (rdy_q !== 1'b1)
    begin
      $display("wrong value at %0t: bus ready timed out", $time);
      testbench.errors++;
      testbench.summarize();
    end
  endtask

  task automatic xfer(input logic [7:0] addr, input logic wr, input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    wait_rdy();
    rdata = rdata_q;
  endtask
endmodule
`default_nettype wire

// ===== camcd_pkg.sv
// Shared constants and types for the camera mode command decoder
package camcd_pkg;
  // Register byte offsets
  localparam logic [7:0] CAMCD_CMD_OFF = 8'h00;
  localparam logic [7:0] CAMCD_QSEL_OFF = 8'h04;
  localparam logic [7:0] CAMCD_QRESP_OFF = 8'h08;
  localparam logic [7:0] CAMCD_STAT_OFF = 8'h0C;
  // Command word fields
  localparam int CAMCD_CODE_LSB = 24;
  localparam int CAMCD_PARAM_W = 17;
  // Command codes
  localparam logic [7:0] CAMCD_C_ACQ = 8'h01;
  localparam logic [7:0] CAMCD_C_FRM = 8'h02;
  localparam logic [7:0] CAMCD_C_EXM = 8'h03;
  localparam logic [7:0] CAMCD_C_SCAN = 8'h04;
  localparam logic [7:0] CAMCD_C_WIDTH = 8'h05;
  localparam logic [7:0] CAMCD_C_LINES = 8'h06;
  localparam logic [7:0] CAMCD_C_MSEC = 8'h07;
  // Parameter letters, sent as ASCII
  localparam logic [16:0] CH_A = 17'h00041;
  localparam logic [16:0] CH_E = 17'h00045;
  localparam logic [16:0] CH_F = 17'h00046;
  localparam logic [16:0] CH_I = 17'h00049;
  localparam logic [16:0] CH_L = 17'h0004C;
  localparam logic [16:0] CH_N = 17'h0004E;
  localparam logic [16:0] CH_O = 17'h0004F;
  localparam logic [16:0] CH_S = 17'h00053;
  localparam logic [16:0] CH_T = 17'h00054;
  // Output width values
  localparam logic [16:0] W_12 = 17'h0000C;
  localparam logic [16:0] W_10 = 17'h0000A;
  localparam logic [16:0] W_8 = 17'h00008;
  // Setting limits and initial values
  localparam logic [16:0] LINES_MIN = 17'h00001;
  localparam logic [16:0] LINES_MAX = 17'h0B02C;
  localparam logic [16:0] LINES_INIT = 17'h001C4;
  localparam logic [16:0] MSEC_MIN = 17'h00001;
  localparam logic [16:0] MSEC_MAX = 17'h1869F;
  localparam logic [16:0] MSEC_INIT = 17'h00064;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINE_TIME_NS = 221400;
  localparam int LINE_CYC = LINE_TIME_NS / CLK_PERIOD_NS;
  localparam int MSEC_NS = 1000000;
  localparam int MSEC_CYC = MSEC_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {FR_NORMAL = 2'h0, FR_SHUTTER = 2'h1, FR_FRAMEBL = 2'h2, FR_TIME = 2'h3} camcd_fr_t;
  typedef enum logic [1:0] {EX_EDGE = 2'h0, EX_TIME = 2'h1, EX_LEVEL = 2'h2} camcd_ex_t;
  typedef enum logic [1:0] {SC_BIN = 2'h0, SC_SUBARR = 2'h1, SC_INTERL = 2'h2, SC_OUTLINE = 2'h3} camcd_scan_t;
  typedef enum logic [1:0] {WD_12 = 2'h0, WD_10 = 2'h1, WD_8 = 2'h2} camcd_wd_t;

  typedef struct packed {
    logic acq_ext;
    camcd_fr_t fr_method;
    camcd_ex_t ex_method;
    camcd_scan_t scan;
    camcd_wd_t width;
  } camcd_modes_t;

  localparam camcd_modes_t MODES_INIT = '{acq_ext: 1'b0, fr_method: FR_NORMAL, ex_method: EX_EDGE,
                                         scan: SC_BIN, width: WD_12};
endpackage

// ===== camcd_top.sv
// Camera mode command decoder with exposure sequencer and pixel bus formatter
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R1] - Acquire command takes N for free running or E for external start.
// [R2] - With E, exposures start only from the external trigger.
// [R3] - Free-run method command takes N, S, F or T.
// [R4] - Method N exposes for the normal default duration.
// [R5] - Method S times exposure with the electronic shutter length.
// [R6] - Method F lengthens exposure by frame blanking.
// [R7] - Method T exposes for the programmed millisecond time.
// [R8] - External method command takes E, T or L.
// [R9] - External E exposes for the shutter line count.
// [R10] - External T exposes for the programmed millisecond time.
// [R11] - External L exposes while the trigger stays high.
// [R12] - Scan command takes S, A, I or O for readout pattern.
// [R13] - Width 12 drives all twelve bits on the pixel bus.
// [R14] - Width 10 drives the top ten bits on bus bits 9..0.
// [R15] - Width 8 drives the top eight bits on bus bits 7..0.
// [R16] - Shutter line count spans 1 to 45100, starts at 452.
// [R17] - Millisecond time starts at 100 ms.
// [R18] - Each setting can be read back through a query.
// [R19] - Unknown parameters leave the setting unchanged.
module camcd_top
  import camcd_pkg::*;
#(
  parameter int MSEC_CYCLES = MSEC_CYC,
  parameter int NORMAL_LINES = 452,
  parameter int SHUTTER_LINES = 452,
  parameter int BLANK_FRAMES = 2,
  parameter int PIX_W = 12
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic trig_in,
  input wire logic [PIX_W-1:0] pixel_in,
  input wire logic pixel_in_valid,
  output logic [PIX_W-1:0] pixel_bus,
  output logic pixel_bus_valid,
  output logic exposing,
  output logic readout_start,
  output camcd_modes_t modes
);

  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_EXPOSE = 3'b010, ST_READ = 3'b100} camcd_state_t;

  camcd_state_t state_reg;
  camcd_modes_t modes_reg;
  logic [16:0] lines_reg;
  logic [16:0] msec_reg;
  logic [7:0] qsel_reg;
  logic [31:0] cnt_reg;
  logic trig_d_reg;
  logic err_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [PIX_W-1:0] pixel_bus_reg;
  logic pixel_bus_valid_reg;
  logic exposing_reg;
  logic readout_reg;

  logic addr_take;
  logic cmd_wr;
  logic [7:0] cmd_code;
  logic [16:0] cmd_param;
  logic trig_rise;

  // Query answer for a command code; used only by bus reads of the query response
  function automatic logic [31:0] query_value(input logic [7:0] code, input camcd_modes_t m,
                                              input logic [16:0] lines, input logic [16:0] msec);
    logic [16:0] v;
    v = 17'h00000;
    case (code)
      CAMCD_C_ACQ: v = m.acq_ext ? CH_E : CH_N;
      CAMCD_C_FRM:
        case (m.fr_method)
          FR_SHUTTER: v = CH_S;
          FR_FRAMEBL: v = CH_F;
          FR_TIME: v = CH_T;
          default: v = CH_N;
        endcase
      CAMCD_C_EXM:
        case (m.ex_method)
          EX_TIME: v = CH_T;
          EX_LEVEL: v = CH_L;
          default: v = CH_E;
        endcase
      CAMCD_C_SCAN:
        case (m.scan)
          SC_SUBARR: v = CH_A;
          SC_INTERL: v = CH_I;
          SC_OUTLINE: v = CH_O;
          default: v = CH_S;
        endcase
      CAMCD_C_WIDTH:
        case (m.width)
          WD_10: v = W_10;
          WD_8: v = W_8;
          default: v = W_12;
        endcase
      CAMCD_C_LINES: v = lines;
      CAMCD_C_MSEC: v = msec;
      default: v = 17'h00000;
    endcase
    return {15'h0000, v};
  endfunction

  // Exposure length in clock cycles for the current settings
  function automatic logic [31:0] exp_cycles(input camcd_modes_t m, input logic [16:0] lines,
                                             input logic [16:0] msec);
    logic [31:0] c;
    c = 32'(NORMAL_LINES) * 32'(LINE_CYC);
    if (m.acq_ext)
    begin
      if (m.ex_method == EX_TIME)
        c = 32'(msec) * 32'(MSEC_CYCLES);
      else
        c = 32'(lines) * 32'(LINE_CYC);
    end
    else
    begin
      case (m.fr_method)
        FR_SHUTTER: c = 32'(SHUTTER_LINES) * 32'(LINE_CYC);
        FR_FRAMEBL: c = 32'(NORMAL_LINES) * 32'(LINE_CYC) * 32'(BLANK_FRAMES);
        FR_TIME: c = 32'(msec) * 32'(MSEC_CYCLES);
        default: c = 32'(NORMAL_LINES) * 32'(LINE_CYC);
      endcase
    end
    return c;
  endfunction

  assign addr_take = hsel && hready && htrans[1];
  assign cmd_wr = wr_pend_reg && (wr_addr_reg == CAMCD_CMD_OFF);
  assign cmd_code = hwdata[CAMCD_CODE_LSB +: 8];
  assign cmd_param = hwdata[CAMCD_PARAM_W-1:0];
  assign trig_rise = trig_in && !trig_d_reg;

  // Bus slave: zero wait state, always OKAY
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= addr_take && hwrite;
      wr_addr_reg <= {haddr[7:2], 2'b00};
      hrdata_reg <= 32'h00000000;
      if (addr_take && !hwrite)
      begin
        case ({haddr[7:2], 2'b00})
          CAMCD_QSEL_OFF: hrdata_reg <= {24'h000000, qsel_reg};
          CAMCD_QRESP_OFF: hrdata_reg <= query_value(qsel_reg, modes_reg, lines_reg, msec_reg); // [R18]
          CAMCD_STAT_OFF: hrdata_reg <= {26'h0000000, err_reg, state_reg, trig_in, modes_reg.acq_ext};
          default: hrdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // Query selector
  always_ff @(posedge clk)
  begin
    if (rst)
      qsel_reg <= CAMCD_C_ACQ;
    else if (wr_pend_reg && wr_addr_reg == CAMCD_QSEL_OFF)
      qsel_reg <= hwdata[7:0];
  end

  // Command decode; a bad parameter only raises the error bit, which the next good command clears
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      modes_reg <= MODES_INIT;
      lines_reg <= LINES_INIT; // [R16]
      msec_reg <= MSEC_INIT; // [R17]
      err_reg <= 1'b0;
    end
    else if (cmd_wr)
    begin
      err_reg <= 1'b1;
      case (cmd_code)
        CAMCD_C_ACQ:
          if (cmd_param == CH_N || cmd_param == CH_E) // [R1] [R19]
          begin
            modes_reg.acq_ext <= (cmd_param == CH_E);
            err_reg <= 1'b0;
          end
        CAMCD_C_FRM:
          if (cmd_param == CH_N || cmd_param == CH_S || cmd_param == CH_F || cmd_param == CH_T) // [R3]
          begin
            modes_reg.fr_method <= (cmd_param == CH_S) ? FR_SHUTTER : (cmd_param == CH_F) ? FR_FRAMEBL :
                                   (cmd_param == CH_T) ? FR_TIME : FR_NORMAL;
            err_reg <= 1'b0;
          end
        CAMCD_C_EXM:
          if (cmd_param == CH_E || cmd_param == CH_T || cmd_param == CH_L) // [R8]
          begin
            modes_reg.ex_method <= (cmd_param == CH_T) ? EX_TIME : (cmd_param == CH_L) ? EX_LEVEL : EX_EDGE;
            err_reg <= 1'b0;
          end
        CAMCD_C_SCAN:
          if (cmd_param == CH_S || cmd_param == CH_A || cmd_param == CH_I || cmd_param == CH_O) // [R12]
          begin
            modes_reg.scan <= (cmd_param == CH_A) ? SC_SUBARR : (cmd_param == CH_I) ? SC_INTERL :
                              (cmd_param == CH_O) ? SC_OUTLINE : SC_BIN;
            err_reg <= 1'b0;
          end
        CAMCD_C_WIDTH:
          if (cmd_param == W_12 || cmd_param == W_10 || cmd_param == W_8)
          begin
            modes_reg.width <= (cmd_param == W_10) ? WD_10 : (cmd_param == W_8) ? WD_8 : WD_12;
            err_reg <= 1'b0;
          end
        CAMCD_C_LINES:
          if (cmd_param >= LINES_MIN && cmd_param <= LINES_MAX) // [R16] [R19]
          begin
            lines_reg <= cmd_param;
            err_reg <= 1'b0;
          end
        CAMCD_C_MSEC:
          if (cmd_param >= MSEC_MIN && cmd_param <= MSEC_MAX) // [R17]
          begin
            msec_reg <= cmd_param;
            err_reg <= 1'b0;
          end
        default: err_reg <= 1'b1;
      endcase
    end
  end

  // Exposure sequencer; the length is fixed at exposure start, but the level end test follows the live modes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 32'h00000000;
      exposing_reg <= 1'b0;
      readout_reg <= 1'b0;
      trig_d_reg <= 1'b0;
    end
    else
    begin
      trig_d_reg <= trig_in;
      readout_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
          if ((!modes_reg.acq_ext) ||
              (modes_reg.ex_method == EX_LEVEL && trig_in) ||
              (modes_reg.ex_method != EX_LEVEL && trig_rise)) // [R2] [R11]
          begin
            state_reg <= ST_EXPOSE;
            exposing_reg <= 1'b1;
            cnt_reg <= exp_cycles(modes_reg, lines_reg, msec_reg) - 32'h00000001; // [R4] [R5] [R6] [R7] [R9] [R10]
          end
        ST_EXPOSE:
          if (modes_reg.acq_ext && modes_reg.ex_method == EX_LEVEL ? !trig_in : cnt_reg == 32'h00000000) // [R11]
          begin
            state_reg <= ST_READ;
            exposing_reg <= 1'b0;
            readout_reg <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg - 32'h00000001;
        ST_READ:
          state_reg <= ST_IDLE;
        default:
        begin
          state_reg <= ST_IDLE;
          exposing_reg <= 1'b0;
        end
      endcase
    end
  end

  // Pixel bus: narrower widths keep the most significant bits
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pixel_bus_reg <= '0;
      pixel_bus_valid_reg <= 1'b0;
    end
    else
    begin
      pixel_bus_valid_reg <= pixel_in_valid;
      if (pixel_in_valid)
      begin
        case (modes_reg.width)
          WD_10: pixel_bus_reg <= {2'b00, pixel_in[PIX_W-1:2]}; // [R14]
          WD_8: pixel_bus_reg <= {4'h0, pixel_in[PIX_W-1:4]}; // [R15]
          default: pixel_bus_reg <= pixel_in; // [R13]
        endcase
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pixel_bus = pixel_bus_reg;
  assign pixel_bus_valid = pixel_bus_valid_reg;
  assign exposing = exposing_reg;
  assign readout_start = readout_reg;
  assign modes = modes_reg;

  sequence s_acq_e;
    cmd_wr && cmd_code == CAMCD_C_ACQ && cmd_param == CH_E;
  endsequence
  sequence s_acq_bad;
    cmd_wr && cmd_code == CAMCD_C_ACQ && cmd_param != CH_E && cmd_param != CH_N;
  endsequence

  property p_acq_ext;
    @(posedge clk) disable iff (rst) s_acq_e |=> modes_reg.acq_ext;
  endproperty
  a_acq_ext: assert property (p_acq_ext) else $error("acquire E not taken"); // [R1]

  property p_acq_bad;
    @(posedge clk) disable iff (rst) s_acq_bad |=> $stable(modes_reg.acq_ext);
  endproperty
  a_acq_bad: assert property (p_acq_bad) else $error("bad acquire parameter changed mode"); // [R19]

  property p_frm_shut;
    @(posedge clk) disable iff (rst) cmd_wr && cmd_code == CAMCD_C_FRM && cmd_param == CH_S
      |=> modes_reg.fr_method == FR_SHUTTER && !err_reg;
  endproperty
  a_frm_shut: assert property (p_frm_shut) else $error("free-run shutter method not taken"); // [R3]

  property p_exm_level;
    @(posedge clk) disable iff (rst) cmd_wr && cmd_code == CAMCD_C_EXM && cmd_param == CH_L
      |=> modes_reg.ex_method == EX_LEVEL;
  endproperty
  a_exm_level: assert property (p_exm_level) else $error("external level method not taken"); // [R8]

  property p_scan_outline;
    @(posedge clk) disable iff (rst) cmd_wr && cmd_code == CAMCD_C_SCAN && cmd_param == CH_O
      |=> modes_reg.scan == SC_OUTLINE;
  endproperty
  a_scan_outline: assert property (p_scan_outline) else $error("outline scan not taken"); // [R12]

  property p_width10;
    @(posedge clk) disable iff (rst) pixel_in_valid && modes_reg.width == WD_10
      |=> pixel_bus_reg == {2'b00, $past(pixel_in[PIX_W-1:2])};
  endproperty
  a_width10: assert property (p_width10) else $error("10-bit pixel formatting wrong"); // [R14]

  property p_lines_zero;
    @(posedge clk) disable iff (rst) cmd_wr && cmd_code == CAMCD_C_LINES && cmd_param == 17'h00000
      |=> $stable(lines_reg) && err_reg;
  endproperty
  a_lines_zero: assert property (p_lines_zero) else $error("zero line count accepted"); // [R16]

  property p_level_end;
    @(posedge clk) disable iff (rst) state_reg == ST_EXPOSE && modes_reg.acq_ext &&
      modes_reg.ex_method == EX_LEVEL && !trig_in |=> !exposing_reg ##1 !exposing_reg;
  endproperty
  a_level_end: assert property (p_level_end) else $error("level exposure outlived trigger"); // [R11]

  property p_edge_start;
    @(posedge clk) disable iff (rst) state_reg == ST_IDLE && modes_reg.acq_ext &&
      modes_reg.ex_method == EX_EDGE && trig_rise
      |=> exposing_reg && cnt_reg == $past(32'(lines_reg)) * 32'(LINE_CYC) - 32'h00000001;
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("edge exposure length wrong"); // [R9]

  property p_query_acq;
    @(posedge clk) disable iff (rst) addr_take && !hwrite && haddr[7:0] == CAMCD_QRESP_OFF && qsel_reg == CAMCD_C_ACQ
      |=> hrdata_reg == ($past(modes_reg.acq_ext) ? 32'h00000045 : 32'h0000004E);
  endproperty
  a_query_acq: assert property (p_query_acq) else $error("acquire query answer wrong"); // [R18]

endmodule

`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the camera mode command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench
  import camcd_pkg::*;
;
  // Short counts keep exposures to a few thousand cycles
  localparam int MS_CYC = 10;
  localparam int NORM_L = 1;
  localparam int SHUT_L = 3;
  localparam int BLANK_F = 2;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, trig_in, pixel_in_valid;
  logic pixel_bus_valid, exposing, readout_start;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] pixel_in, pixel_bus;
  camcd_modes_t modes;
  int errors;
  int checks_done;

  camcd_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  camcd_top #(.MSEC_CYCLES(MS_CYC), .NORMAL_LINES(NORM_L), .SHUTTER_LINES(SHUT_L), .BLANK_FRAMES(BLANK_F),
    .PIX_W(12)) dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .trig_in(trig_in), .pixel_in(pixel_in), .pixel_in_valid(pixel_in_valid),
    .pixel_bus(pixel_bus), .pixel_bus_valid(pixel_bus_valid), .exposing(exposing),
    .readout_start(readout_start), .modes(modes));

  always #50 clk = ~clk;

  task automatic summarize();
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] code, input logic [16:0] prm);
    logic [31:0] d;
    host.xfer(CAMCD_CMD_OFF, 1'b1, {code, 7'h00, prm}, d);
  endtask

  task automatic query(input logic [7:0] code, input logic [16:0] exp);
    logic [31:0] d;
    host.xfer(CAMCD_QSEL_OFF, 1'b1, {24'h000000, code}, d);
    host.xfer(CAMCD_QRESP_OFF, 1'b0, 32'h00000000, d);
    check(d, {15'h0000, exp}, "query answer");
    check({31'h00000000, hresp}, 32'h00000000, "bus response");
  endtask

  function automatic logic [1:0] field(input logic [7:0] code);
    case (code)
      CAMCD_C_ACQ: field = {1'b0, modes.acq_ext};
      CAMCD_C_FRM: field = modes.fr_method;
      CAMCD_C_EXM: field = modes.ex_method;
      CAMCD_C_SCAN: field = modes.scan;
      default: field = modes.width;
    endcase
  endfunction

  task automatic t_reset();
    logic [31:0] d;
    check(modes, MODES_INIT, "modes after reset");
    query(CAMCD_C_LINES, LINES_INIT);
    query(CAMCD_C_MSEC, MSEC_INIT);
    query(CAMCD_C_ACQ, CH_N);
    host.xfer(8'h10, 1'b0, 32'h00000000, d);
    check(d, 32'h00000000, "unmapped read");
    host.xfer(8'h14, 1'b1, 32'h0400004C, d);
    host.xfer(CAMCD_CMD_OFF, 1'b0, 32'h00000000, d);
    check(d, 32'h00000000, "command word read");
    check(modes, MODES_INIT, "unmapped write");
  endtask

  task automatic t_modes();
    logic [31:0] d;
    logic [7:0] c [16] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h02, 8'h02, 8'h03, 8'h03, 8'h03, 8'h04, 8'h04,
      8'h04, 8'h04, 8'h05, 8'h05, 8'h05};
    logic [16:0] p [16] = '{CH_E, CH_N, CH_S, CH_F, CH_T, CH_N, CH_T, CH_L, CH_E, CH_A, CH_I, CH_O, CH_S,
      W_10, W_8, W_12};
    logic [1:0] f [16] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0,
      2'h1, 2'h2, 2'h0};
    for (int i = 0; i < 16; i++)
    begin
      cmd(c[i], p[i]);
      check(field(c[i]), f[i], "mode field");
      query(c[i], p[i]);
    end
    cmd(CAMCD_C_ACQ, CH_T);
    cmd(CAMCD_C_WIDTH, 17'h00009);
    check(modes, MODES_INIT, "bad parameter");
    host.xfer(CAMCD_STAT_OFF, 1'b0, 32'h00000000, d);
    check(d & 32'h00000021, 32'h00000020, "error flag after bad parameter");
    cmd(CAMCD_C_ACQ, CH_N);
    host.xfer(CAMCD_STAT_OFF, 1'b0, 32'h00000000, d);
    check(d & 32'h00000021, 32'h00000000, "error flag after good command");
    cmd(CAMCD_C_LINES, 17'h00000);
    cmd(CAMCD_C_LINES, 17'h0B02D);
    query(CAMCD_C_LINES, LINES_INIT);
    cmd(CAMCD_C_LINES, LINES_MAX);
    query(CAMCD_C_LINES, LINES_MAX);
  endtask

  task automatic t_pixel();
    logic [16:0] w [3] = '{W_12, W_10, W_8};
    logic [11:0] e [3] = '{12'hABC, 12'h2AF, 12'h0AB};
    for (int i = 0; i < 3; i++)
    begin
      cmd(CAMCD_C_WIDTH, w[i]);
      @(posedge clk);
      pixel_in <= 12'hABC;
      pixel_in_valid <= 1'b1;
      @(posedge clk);
      pixel_in_valid <= 1'b0;
      #1;
      check({pixel_bus_valid, pixel_bus}, {1'b1, e[i]}, "pixel bus");
    end
  endtask

  task automatic waitx(input logic lvl, output int n);
    n = 0;
    while (exposing !== lvl)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 20000)
      begin
        errors++;
        $display("wrong value at %0t: exposure wait timed out", $time);
        summarize();
      end
    end
  endtask

  task automatic expo(input logic ext, input logic [16:0] meth, input int hold, input int len);
    int n;
    int hi;
    cmd(ext ? CAMCD_C_EXM : CAMCD_C_FRM, meth);
    cmd(CAMCD_C_ACQ, ext ? CH_E : CH_N);
    // Any exposure begun under the old settings is let run out first
    waitx(1'b0, n);
    if (ext)
    begin
      hi = 0;
      repeat (2300)
      begin
        @(posedge clk);
        #1;
        if (exposing !== 1'b0)
          hi++;
      end
      check(hi, 0, "start without trigger");
      fork
        begin
          @(posedge clk);
          trig_in <= 1'b1;
          repeat (hold) @(posedge clk);
          trig_in <= 1'b0;
        end
      join_none
    end
    waitx(1'b1, n);
    waitx(1'b0, n);
    check(n, len, "exposure length");
    check(readout_start, 1'b1, "readout pulse");
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    trig_in = 1'b0;
    pixel_in = 12'h000;
    pixel_in_valid = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_pixel();
    cmd(CAMCD_C_LINES, 17'h00002);
    cmd(CAMCD_C_MSEC, 17'h00003);
    expo(1'b0, CH_N, 0, LINE_CYC * NORM_L);
    expo(1'b0, CH_S, 0, LINE_CYC * SHUT_L);
    expo(1'b0, CH_F, 0, LINE_CYC * NORM_L * BLANK_F);
    expo(1'b0, CH_T, 0, 3 * MS_CYC);
    expo(1'b1, CH_E, 1, 2 * LINE_CYC);
    expo(1'b1, CH_T, 1, 3 * MS_CYC);
    expo(1'b1, CH_L, 25, 25);
    summarize();
  end
endmodule
`default_nettype wire
